// ---- logic/pdpo_cfg_if.sv ----
// Interface: write strobes and readback between the top and the per-port store
`timescale 1ns/10ps
interface pdpo_cfg_if;
  logic       opt_we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [2:0] out_mode [8];
  logic [1:0] in_mode  [8];
  modport master (output opt_we, output wdata, input rdata, input out_mode, input in_mode);
  modport slave  (input opt_we, input wdata, output rdata, output out_mode, output in_mode);
endinterface : pdpo_cfg_if

// ---- logic/pdpo_opt_store.sv ----
// Per-port pin option store with indirect read selection
`timescale 1ns/10ps
module pdpo_opt_store
  import pdpo_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  input  wire logic   [7:0] pin_present,
  pdpo_cfg_if.slave   cfg
);
  logic [2:0] out_q [PDPO_PINS];
  logic [1:0] in_q  [PDPO_PINS];
  logic [2:0] sel_idx_q;
  logic       sel_side_q;
  logic [7:0] rdata_q;

  wire        rd_select  = cfg.wdata[PDPO_F_RDSEL];
  wire        side_in    = cfg.wdata[PDPO_F_SIDE];
  wire [2:0]  pin_idx    = cfg.wdata[PDPO_F_IDX_HI:0];
  wire [2:0]  mode_field = cfg.wdata[PDPO_F_MODE_HI:PDPO_F_MODE_LO];
  wire        cfg_write  = cfg.opt_we && !rd_select;

  genvar g;
  generate
    for (g = 0; g < PDPO_PINS; g++) begin : g_pin
      wire hit = cfg_write && (pin_idx == 3'(g)) && pin_present[g];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          out_q[g] <= PDPO_MODE_RESET;
          in_q[g]  <= PDPO_MODE_RESET[1:0];
        end else if (hit && side_in) begin
          in_q[g]  <= mode_field[1:0];
        end else if (hit && (mode_field == PDPO_OUT_NORMAL || mode_field == PDPO_OUT_HIGH)) begin
          out_q[g] <= mode_field;
        end
      end
      assign cfg.out_mode[g] = out_q[g];
      assign cfg.in_mode[g]  = in_q[g];
    end
  endgenerate

  // read-select saves index and side only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_idx_q  <= 3'h0;
      sel_side_q <= 1'b0;
    end else if (cfg.opt_we && rd_select) begin
      sel_idx_q  <= pin_idx;
      sel_side_q <= side_in;
    end
  end

  // mode of selected pin in 7:5; side 0 reads output
  wire [2:0] sel_mode = sel_side_q ? {1'b0, in_q[sel_idx_q]} : out_q[sel_idx_q];
  always_ff @(posedge aclk) begin
    if (!aresetn) rdata_q <= PDPO_OPT_RESET;
    else          rdata_q <= {sel_mode, sel_side_q, 1'b0, sel_idx_q};
  end
  assign cfg.rdata = rdata_q;
endmodule : pdpo_opt_store

// ---- logic/pdpo_pkg.sv ----
// Package: register map, field layout and reset values for the port configuration block
package pdpo_pkg;
  localparam int          PDPO_MAX_PORTS   = 4;
  localparam int          PDPO_PINS        = 8;
  localparam int          PDPO_ADDR_W      = 12;
  // Printed offsets are not multiples of four: they are register indices
  localparam logic [7:0]  PDPO_IDX_DIR0    = 8'h93;
  localparam logic [7:0]  PDPO_IDX_DIR1    = 8'h94;
  localparam logic [7:0]  PDPO_IDX_DIR2    = 8'h95;
  localparam logic [7:0]  PDPO_IDX_DIR3    = 8'h96;
  localparam logic [7:0]  PDPO_IDX_OPT0    = 8'h9e;
  localparam logic [7:0]  PDPO_IDX_OPT1    = 8'h9f;
  localparam logic [7:0]  PDPO_IDX_OPT2    = 8'ha0;
  localparam logic [7:0]  PDPO_IDX_OPT3    = 8'ha1;
  localparam logic [7:0]  PDPO_DIR_RESET   = 8'hff;
  localparam logic [7:0]  PDPO_OPT_RESET   = 8'h00;
  localparam logic [2:0]  PDPO_MODE_RESET  = 3'h0;
  // Option register fields
  localparam int          PDPO_F_MODE_HI   = 7;
  localparam int          PDPO_F_MODE_LO   = 5;
  localparam int          PDPO_F_SIDE      = 4;
  localparam int          PDPO_F_RDSEL     = 3;
  localparam int          PDPO_F_IDX_HI    = 2;
  // Output codes; input codes use the low two bits of the mode field
  localparam logic [2:0]  PDPO_OUT_NORMAL  = 3'h0;
  localparam logic [2:0]  PDPO_OUT_HIGH    = 3'h3;
  localparam logic [1:0]  PDPO_IN_NOPULL   = 2'h0;
  localparam logic [1:0]  PDPO_IN_PULLDN   = 2'h1;
  localparam logic [1:0]  PDPO_IN_PULLUP   = 2'h2;
  localparam logic [1:0]  PDPO_IN_OFF      = 2'h3;
  localparam logic [1:0]  PDPO_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PDPO_RESP_SLVERR = 2'h2;
  localparam int          PDPO_PKG_24      = 24;
  localparam int          PDPO_PKG_32      = 32;
  localparam int          PDPO_PKG_48      = 48;
endpackage : pdpo_pkg

// ---- logic/pdpo_top.sv ----
// Top: port direction and pin option registers behind an AXI4-Lite slave
//
// Overview of operation
// - After reset every pin is an input and each present pin's level goes to the core input path; absent pins such as port 3 bit 7 read 0.
// - Direction bit n governs pin n, 0 meaning output and 1 meaning input.
// - Four read/write direction registers sit at consecutive indices, port 0 to port 3.
// - Bit 7 of the port 3 direction register is reserved.
// - The eighth pin of ports 0 and 1 exists only in the 32 and 48 pin packages.
// - One to four ports are implemented, set by a parameter.
// - Each port has an option register apart from its direction register.
// - One option write configures only the single pin it names.
// - Read-select with side 0 chooses the output options for later reads.
// - An option read returns the selected pin's mode in bits 7:5.
// - Output codes are 000 normal and 011 high drive; other codes are not stored.
// - Input codes in bits 6:5 are no pull, pull-down, pull-up and buffer off.
// - A read-select write leaves stored modes untouched.
// - A configuring write goes to input options for side 1, output options for side 0.
`timescale 1ns/10ps
module pdpo_top
  import pdpo_pkg::*;
#(
  parameter int NUM_PORTS = 4,
  parameter int PKG_PINS  = 48
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] pin_in,
  output logic [31:0]      pin_out_en_n,
  output logic [31:0]      core_pin_input,
  output logic [31:0]      pin_high_drive,
  output logic [31:0]      pin_pull_up,
  output logic [31:0]      pin_pull_down,
  output logic [31:0]      pin_in_buf_off
);
  // eighth pin of low ports only in larger packages
  localparam bit BIG_PKG = (PKG_PINS == PDPO_PKG_32) || (PKG_PINS == PDPO_PKG_48);

  logic [7:0]  present [PDPO_MAX_PORTS];
  logic [7:0]  dir_q   [PDPO_MAX_PORTS];
  logic [7:0]  opt_rd  [PDPO_MAX_PORTS];
  logic [31:0] pin_s1_q;
  logic [31:0] pin_s2_q;

  // Write and read channel state: write address and data may arrive in either order
  logic        aw_held_q;
  logic        w_held_q;
  logic [9:0]  aw_idx_q;
  logic [7:0]  wbyte_q;
  logic        wlane_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic        rd_pend_q;
  logic [9:0]  ar_idx_q;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rd_pend_q && !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire do_wr   = aw_held_q && w_held_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= 10'h000;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[11:2];
      end else if (do_wr) begin
        aw_held_q <= 1'b0;
      end
      if (w_fire) begin
        w_held_q <= 1'b1;
        wbyte_q  <= s_axi_wdata[7:0];
        wlane_q  <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Register decode on word index
  wire        wr_map = (aw_idx_q[9:8] == 2'h0);
  wire [7:0]  wr_idx = aw_idx_q[7:0];
  wire [2:0]  wr_dir_sel = 3'(wr_idx - PDPO_IDX_DIR0);
  wire [2:0]  wr_opt_sel = 3'(wr_idx - PDPO_IDX_OPT0);
  wire        wr_is_dir = wr_map && wr_idx >= PDPO_IDX_DIR0 && wr_idx <= PDPO_IDX_DIR3
                          && 32'(wr_dir_sel) < NUM_PORTS;
  wire        wr_is_opt = wr_map && wr_idx >= PDPO_IDX_OPT0 && wr_idx <= PDPO_IDX_OPT3
                          && 32'(wr_opt_sel) < NUM_PORTS;
  wire        wr_ok     = wr_is_dir || wr_is_opt;

  wire        rd_map = (ar_idx_q[9:8] == 2'h0);
  wire [7:0]  rd_idx = ar_idx_q[7:0];
  wire [2:0]  rd_dir_sel = 3'(rd_idx - PDPO_IDX_DIR0);
  wire [2:0]  rd_opt_sel = 3'(rd_idx - PDPO_IDX_OPT0);
  wire        rd_is_dir = rd_map && rd_idx >= PDPO_IDX_DIR0 && rd_idx <= PDPO_IDX_DIR3
                          && 32'(rd_dir_sel) < NUM_PORTS;
  wire        rd_is_opt = rd_map && rd_idx >= PDPO_IDX_OPT0 && rd_idx <= PDPO_IDX_OPT3
                          && 32'(rd_opt_sel) < NUM_PORTS;
  wire [7:0]  rd_byte   = rd_is_dir ? dir_q[rd_dir_sel[1:0]] :
                          rd_is_opt ? opt_rd[rd_opt_sel[1:0]] : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= PDPO_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? PDPO_RESP_OKAY : PDPO_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Address captured one cycle, data registered the next
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_q <= 1'b0;
      ar_idx_q  <= 10'h000;
      rvalid_q  <= 1'b0;
      rresp_q   <= PDPO_RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_pend_q <= 1'b1;
      ar_idx_q  <= s_axi_araddr[11:2];
    end else if (rd_pend_q) begin
      rd_pend_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= (rd_is_dir || rd_is_opt) ? PDPO_RESP_OKAY : PDPO_RESP_SLVERR;
      rdata_q   <= {24'h00_0000, rd_byte};
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
    end
  end

  // Pins are asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 32'h0000_0000;
      pin_s2_q <= 32'h0000_0000;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  genvar p;
  generate
    for (p = 0; p < PDPO_MAX_PORTS; p++) begin : g_port
      localparam bit IMPL = (p < NUM_PORTS);
      // port 3 bit 7 reserved; pin 7 of ports 0, 1 by package
      localparam bit HAS7 = IMPL && (p == 2 || ((p < 2) && BIG_PKG));
      assign present[p] = IMPL ? {HAS7, 7'h7f} : 8'h00;

      pdpo_cfg_if cfg ();
      assign cfg.opt_we = do_wr && wr_is_opt && (wr_opt_sel[1:0] == 2'(p)) && wlane_q;
      assign cfg.wdata  = wbyte_q;
      assign opt_rd[p]  = cfg.rdata;

      pdpo_opt_store u_store (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .pin_present (present[p]),
        .cfg         (cfg)
      );

      // reset leaves all pins as inputs
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          dir_q[p] <= PDPO_DIR_RESET;
        end else if (do_wr && wr_is_dir && (wr_dir_sel[1:0] == 2'(p)) && wlane_q) begin
          dir_q[p] <= wbyte_q | ~present[p];
        end
      end

      for (genvar b = 0; b < PDPO_PINS; b++) begin : g_bit
        localparam int N = p * PDPO_PINS + b;
        assign pin_out_en_n[N]   = dir_q[p][b] | ~present[p][b];
        assign pin_high_drive[N] = (cfg.out_mode[b] == PDPO_OUT_HIGH);
        assign pin_pull_up[N]    = (cfg.in_mode[b] == PDPO_IN_PULLUP);
        assign pin_pull_down[N]  = (cfg.in_mode[b] == PDPO_IN_PULLDN);
        assign pin_in_buf_off[N] = (cfg.in_mode[b] == PDPO_IN_OFF) || !present[p][b];
        assign core_pin_input[N] = pin_s2_q[N] & present[p][b]
                                   & (cfg.in_mode[b] != PDPO_IN_OFF);
      end
    end
  endgenerate
endmodule : pdpo_top

// ---- testbench/pdpo_pad_model.sv ----
// Pad model: external pin levels, floating pins and pull resistors
`timescale 1ns/10ps
module pdpo_pad_model (
  input  wire logic        aclk,
  input  wire logic [31:0] ext_lvl,
  input  wire logic [31:0] flt,
  input  wire logic [31:0] pin_out_en_n,
  input  wire logic [31:0] pin_pull_up,
  input  wire logic [31:0] pin_pull_down,
  output logic      [31:0] pin_in
);
  logic [31:0] tog_q = 32'h0;
  logic [31:0] fl;
  // A floating pin wanders, so a missing pull cannot hide behind a fixed level
  always @(posedge aclk) tog_q <= ~tog_q;
  // driven pins carry no input level
  assign fl = flt | ~pin_out_en_n;
  assign pin_in = (ext_lvl & ~fl) | (fl & (pin_pull_up | (tog_q & ~pin_pull_down)));
endmodule : pdpo_pad_model

// ---- testbench/pdpo_top_sva.sv ----
// Checker: bus timing and pin state properties of the port block
`timescale 1ns/10ps
module pdpo_top_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [31:0] pin_out_en_n,
  input wire logic [31:0] core_pin_input,
  input wire logic [31:0] pin_in_buf_off
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RST_IN: assert property (disable iff (1'b0) !aresetn |=> &pin_out_en_n)
    else $error("pins not inputs after reset");
  AST_P3_B7: assert property (pin_out_en_n[31] && !core_pin_input[31])
    else $error("reserved pin active");
  AST_BUF_OFF: assert property ($stable(pin_in_buf_off) ##1 $stable(pin_in_buf_off)
    |=> (core_pin_input & pin_in_buf_off) == 32'h0) else $error("input seen with buffer off");
  AST_BV: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_RV: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##[1:2] s_axi_rvalid)
    else $error("read data timing");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_UP: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  cover property (s_axi_arvalid && s_axi_arready);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (|pin_in_buf_off[30:0]);
endmodule : pdpo_top_sva
bind pdpo_top pdpo_top_sva i_pdpo_top_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pin_out_en_n, .core_pin_input, .pin_in_buf_off);

// ---- testbench/pdpo_top_tb.sv ----
// Testbench: register access and pin option scenarios for the port block
`timescale 1ns/10ps
module pdpo_top_tb;
  import pdpo_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, ext_lvl = 32'hc3a5_5a3c, flt = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, pin_in, pin_out_en_n, core_pin_input, pin_high_drive;
  logic [31:0] pin_pull_up, pin_pull_down, pin_in_buf_off;
  logic [2:0]  om;
  logic [2:0]  pexp [4] = '{3'h0, 3'h2, 3'h4, 3'h1};
  int          errors = 0, checks_done = 0;
  always #2 aclk = ~aclk;
  pdpo_top i_pdpo_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out_en_n, .core_pin_input, .pin_high_drive,
    .pin_pull_up, .pin_pull_down, .pin_in_buf_off);
  pdpo_pad_model i_pdpo_pad_model (.aclk, .ext_lvl, .flt, .pin_out_en_n, .pin_pull_up,
    .pin_pull_down, .pin_in);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Handshakes are judged on values sampled at the rising edge, before its updates land
  task automatic wr(input logic [7:0] ix, d, input logic [1:0] er);
    logic da, dw, tb;
    logic [1:0] rs;
    da = 1'b0;
    dw = 1'b0;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, ix, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(posedge aclk);
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      if (!da && s_axi_awready) begin
        da = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dw && s_axi_wready) begin
        dw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, rs}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] ix, input logic [1:0] er, input logic [7:0] ed);
    logic t;
    logic [1:0] rs;
    logic [31:0] dv;
    t = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {2'h0, ix, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!t) begin
      @(posedge aclk);
      t = s_axi_arready;
    end
    s_axi_arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(posedge aclk);
      t = s_axi_rvalid;
      rs = s_axi_rresp;
      dv = s_axi_rdata;
    end
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, rs}, {30'h0, er});
    chk("rdata", dv, {24'h0, ed});
  endtask : rd
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int p = 0; p < 4; p++) rd(PDPO_IDX_DIR0 + 8'(p), PDPO_RESP_OKAY, PDPO_DIR_RESET);
    chk("out_en_n", pin_out_en_n, 32'hffff_ffff);
    chk("core_in", core_pin_input, 32'h43a5_5a3c);
    for (int p = 0; p < 4; p++) wr(PDPO_IDX_DIR0 + 8'(p), 8'h3c, PDPO_RESP_OKAY);
    chk("out_en_n", pin_out_en_n, 32'hbc3c_3c3c);
    rd(PDPO_IDX_DIR3, PDPO_RESP_OKAY, 8'hbc);
    rd(PDPO_IDX_DIR1, PDPO_RESP_OKAY, 8'h3c);
    rd(8'h97, PDPO_RESP_SLVERR, 8'h00);
    wr(8'h97, 8'h00, PDPO_RESP_SLVERR);
    wr(PDPO_IDX_DIR1, 8'hff, PDPO_RESP_OKAY);
    om = PDPO_MODE_RESET;
    for (int m = 0; m < 8; m++) begin
      wr(PDPO_IDX_OPT1, {3'(m), 5'h05}, PDPO_RESP_OKAY);
      if (3'(m) == PDPO_OUT_NORMAL || 3'(m) == PDPO_OUT_HIGH) om = 3'(m);
      wr(PDPO_IDX_OPT1, 8'h0d, PDPO_RESP_OKAY);
      rd(PDPO_IDX_OPT1, PDPO_RESP_OKAY, {om, 5'h05});
      chk("hdrive", {31'h0, pin_high_drive[13]}, {31'h0, om == PDPO_OUT_HIGH});
    end
    wr(PDPO_IDX_OPT1, 8'h64, PDPO_RESP_OKAY);
    chk("hdrive", {24'h0, pin_high_drive[15:8]}, 32'h30);
    flt <= 32'h0000_2000;
    for (int m = 0; m < 4; m++) begin
      wr(PDPO_IDX_OPT1, {1'b0, 2'(m), 5'h15}, PDPO_RESP_OKAY);
      wr(PDPO_IDX_OPT1, 8'h1d, PDPO_RESP_OKAY);
      rd(PDPO_IDX_OPT1, PDPO_RESP_OKAY, {1'b0, 2'(m), 5'h15});
      chk("pulls", {29'h0, pin_pull_up[13], pin_pull_down[13], pin_in_buf_off[13]},
          {29'h0, pexp[m]});
      if (m != 0) chk("core13", {31'h0, core_pin_input[13]}, {31'h0, m == 2});
    end
    wr(PDPO_IDX_OPT1, 8'h0d, PDPO_RESP_OKAY);
    rd(PDPO_IDX_OPT1, PDPO_RESP_OKAY, {PDPO_OUT_HIGH, 5'h05});
    end_of_test();
  end
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
endmodule : pdpo_top_tb
